// ==== rtl/sst_pkg.sv ====
// constants, types and register map of the shifter and status transfer block
// assumes a single 125 MHz core clock and a synchronous active high reset
package sst_pkg;

	// ------------------------------------------------------------------
	// register map, byte addresses on the avalon slave
	// ------------------------------------------------------------------
	localparam int SST_ADDR_W = 8;
	localparam logic [7:0] SST_OFF_OPERAND1 = 8'h00; // first operand register value
	localparam logic [7:0] SST_OFF_OPERAND_REG = 8'h04; // operand_reg value
	localparam logic [7:0] SST_OFF_SHIFT_AMOUNT = 8'h08; // shift_amount_register value
	localparam logic [7:0] SST_OFF_INSTR = 8'h0C; // instruction word
	localparam logic [7:0] SST_OFF_INSTR_ADDR = 8'h10; // address of the instruction
	localparam logic [7:0] SST_OFF_CTRL = 8'h14; // write bit 0 to execute
	localparam logic [7:0] SST_OFF_RESULT = 8'h18; // destination value
	localparam logic [7:0] SST_OFF_PC = 8'h1C; // program counter written
	localparam logic [7:0] SST_OFF_STATUS_WORD = 8'h20; // current_status_word
	localparam logic [7:0] SST_OFF_SAVED_WORD = 8'h24; // saved_status_word of current mode
	localparam logic [7:0] SST_OFF_EXEC_INFO = 8'h28; // outcome of last execution
	localparam int SST_CTRL_EXEC_BIT = 0;

	// ------------------------------------------------------------------
	// status word layout
	// ------------------------------------------------------------------
	localparam int SST_PSR_N = 31;
	localparam int SST_PSR_Z = 30;
	localparam int SST_PSR_C = 29;
	localparam int SST_PSR_V = 28;
	localparam logic [31:0] SST_PSR_DEFINED_MASK = 32'hF000_00FF;
	localparam logic [31:0] SST_PSR_FLAGS_MASK = 32'hF000_0000;
	localparam logic [31:0] SST_PSR_RESET = 32'h0000_00D3;
	localparam logic [4:0] SST_MODE_USER = 5'h10;
	localparam logic [4:0] SST_MODE_FIQ = 5'h11;
	localparam logic [4:0] SST_MODE_IRQ = 5'h12;
	localparam logic [4:0] SST_MODE_SVC = 5'h13;
	localparam logic [4:0] SST_MODE_ABT = 5'h17;
	localparam logic [4:0] SST_MODE_UND = 5'h1B;
	localparam int SST_NUM_BANKS = 5;

	// ------------------------------------------------------------------
	// instruction fields and timing figures
	// ------------------------------------------------------------------
	localparam int SST_IB_IMM = 25;
	localparam int SST_IB_SET_FLAGS = 20;
	localparam int SST_IB_MUL_GUARD = 7;
	localparam int SST_IB_REG_SHIFT = 4;
	localparam int SST_IB_PSR_SEL = 22;
	localparam int SST_IB_PSR_DIR = 21;
	localparam int SST_IB_PSR_ALL = 16;
	localparam logic [3:0] SST_REG_PC = 4'hF;
	localparam logic [31:0] SST_PC_AHEAD_IMM = 32'h0000_0008;
	localparam logic [31:0] SST_PC_AHEAD_REG = 32'h0000_000C;
	localparam logic [7:0] SST_SHIFT_32 = 8'h20;
	localparam logic [1:0] SST_S_CYCLES_NORMAL = 2'h1;
	localparam logic [1:0] SST_S_CYCLES_PC = 2'h2;

	// ------------------------------------------------------------------
	// enumerations and carriers
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SST_SHIFT_LEFT_LOGICAL = 2'b00,
		SST_SHIFT_RIGHT_LOGICAL = 2'b01,
		SST_SHIFT_RIGHT_ARITH = 2'b10,
		SST_ROTATE_RIGHT = 2'b11
	} sst_shift_t;

	typedef enum logic [3:0] {
		SST_OP_AND = 4'b0000, SST_OP_EOR = 4'b0001, SST_OP_SUB = 4'b0010,
		SST_OP_RSB = 4'b0011, SST_OP_ADD = 4'b0100, SST_OP_ADC = 4'b0101,
		SST_OP_SBC = 4'b0110, SST_OP_RSC = 4'b0111, SST_BIT_TEST_OP = 4'b1000,
		SST_EQUIVALENCE_TEST_OP = 4'b1001, SST_COMPARE_OP = 4'b1010,
		SST_NEGATED_COMPARE_OP = 4'b1011, SST_OP_ORR = 4'b1100,
		SST_OP_MOV = 4'b1101, SST_OP_BIC = 4'b1110, SST_OP_MVN = 4'b1111
	} sst_opcode_t;

	typedef enum logic {
		SST_BUS_IDLE = 1'b0,
		SST_BUS_ANSWER = 1'b1
	} sst_bus_state_t;

	typedef struct packed {
		logic undef; // not data-processing class, or bit 7 set in a register shift encoding
		logic no_saved; // saved word touched in a mode without one
		logic flags_written; // condition flags updated
		logic psr_restored; // saved word copied into status word
		logic pc_written; // result went to the program counter
		logic rd_written; // result went to a general register
		logic [3:0] rd; // destination index
		logic [1:0] s_cycles; // sequential cycles
		logic n_cycles; // non-sequential cycles
		logic i_cycles; // internal cycles
	} sst_exec_info_t;

endpackage

// ==== rtl/sst_core.sv ====
// data-processing operand path and status transfer unit behind an avalon slave
// assumes a single-word master that holds its request until waitrequest is low
//
// Behaviour
// RULE1 - register shift uses low byte only
// RULE2 - zero shift byte passes operand, carry kept
// RULE3 - shift byte 1..31 matches encoded shift
// RULE4 - left logical 32: zero, carry bit0
// RULE5 - right logical 32: zero, carry bit31
// RULE6 - arithmetic right 32 plus fills sign
// RULE7 - rotate by 32 or more reduces modulo 32
// RULE8 - bit 7 set means multiply/undefined
// RULE9 - immediate rotated right by twice field
// RULE10 - pc destination without flag update
// RULE11 - pc destination with flags restores status
// RULE12 - pc operand reads address plus 8/12
// RULE13 - test ops write flags, not destination
// RULE14 - legacy test restores status when privileged
// RULE15 - cycle counts per processing type
// RULE16 - status read and write transfers
// RULE17 - flags-only write uses top four bits
// RULE18 - unprivileged writes change flags only
// RULE19 - saved word chosen by current mode
// RULE20 - only twelve status bits defined
// RULE21 - software read-modify-writes control bits
// RULE22 - software never alters state bit
// RULE23 - logical ops take shifter carry
//
// Added by the designer: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none

module sst_core (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// avalon-mm slave
	input wire logic [sst_pkg::SST_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// live status word
	output logic [31:0] status_word_out
);
	import sst_pkg::*;

	// ------------------------------------------------------------------
	// shifter helpers, result in [31:0] and carry in [32]
	// ------------------------------------------------------------------
	// amount is a full byte so the 32-and-above cases fall out naturally
	function automatic logic [32:0] sst_shift(input logic [31:0] v, input logic [1:0] kind,
			input logic [7:0] amt, input logic cin);
		logic [32:0] t;
		logic [63:0] w;
		logic [32:0] r;
		t = '0;
		w = '0;
		r = {cin, v};
		if (amt != 8'h00) begin
			case (kind)
				SST_SHIFT_LEFT_LOGICAL: begin
					if (amt <= SST_SHIFT_32) begin
						t = {1'b0, v} << amt; // see RULE3 see RULE4
						r = t;
					end else begin
						r = '0; // see RULE4
					end
				end
				SST_SHIFT_RIGHT_LOGICAL: begin
					if (amt <= SST_SHIFT_32) begin
						t = {v, 1'b0} >> amt; // see RULE3 see RULE5
						r = {t[0], t[32:1]};
					end else begin
						r = '0; // see RULE5
					end
				end
				SST_SHIFT_RIGHT_ARITH: begin
					if (amt >= SST_SHIFT_32) begin
						r = {v[31], {32{v[31]}}}; // see RULE6
					end else begin
						t = 33'($signed({v, 1'b0}) >>> amt); // see RULE3
						r = {t[0], t[32:1]};
					end
				end
				default: begin
					// rotate: only the low five bits matter, zero means by 32
					w = {v, v} >> amt[4:0]; // see RULE7
					r = {w[31], w[31:0]};
				end
			endcase
		end
		return r; // zero amount keeps operand and carry, see RULE2
	endfunction

	// mode to saved-word bank, bit 3 marks a mode that has one
	function automatic logic [3:0] sst_bank(input logic [4:0] mode);
		case (mode)
			SST_MODE_FIQ: sst_bank = 4'h8;
			SST_MODE_IRQ: sst_bank = 4'h9;
			SST_MODE_SVC: sst_bank = 4'hA;
			SST_MODE_ABT: sst_bank = 4'hB;
			SST_MODE_UND: sst_bank = 4'hC;
			default: sst_bank = 4'h0;
		endcase
	endfunction

	// byte-lane merge for register writes
	function automatic logic [31:0] sst_merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	sst_bus_state_t bus_q, bus_d; // idle or answering
	logic wait_q, wait_d; // registered waitrequest
	logic [31:0] rdata_q, rdata_d; // registered read data
	logic [31:0] op1_q, op1_d; // first operand
	logic [31:0] opreg_q, opreg_d; // operand_reg value
	logic [31:0] shamt_q, shamt_d; // shift_amount_register value
	logic [31:0] instr_q, instr_d; // instruction word
	logic [31:0] iaddr_q, iaddr_d; // instruction address
	logic [31:0] result_q, result_d; // last destination value
	logic [31:0] pc_q, pc_d; // last program counter write
	logic [31:0] psr_q, psr_d; // current_status_word
	sst_exec_info_t info_q, info_d; // outcome of last execution
	logic [31:0] bank_q [SST_NUM_BANKS]; // saved words, one per mode except user
	logic [31:0] bank_d [SST_NUM_BANKS];
	logic bank_wr; // write the current mode's saved word
	logic [31:0] bank_wdata;

	// bus qualifiers
	logic req; // read or write pending
	logic fire; // access takes effect at this edge
	logic wr_fire; // write takes effect at this edge
	logic [7:0] word_addr; // byte address with lane bits cleared
	logic exec; // start of an execution

	// current mode and its bank
	logic [3:0] cur_bank; // bank code of current mode
	logic privileged; // any mode but the unprivileged one
	logic [31:0] cur_saved; // saved word of current mode, zero if none

	assign req = avs_read | avs_write;
	assign fire = req && (bus_q == SST_BUS_ANSWER);
	assign wr_fire = fire && avs_write;
	assign word_addr = {avs_address[7:2], 2'b00};
	assign exec = wr_fire && (word_addr == SST_OFF_CTRL) && avs_byteenable[0]
		&& avs_writedata[SST_CTRL_EXEC_BIT];
	assign cur_bank = sst_bank(psr_q[4:0]); // see RULE19
	assign privileged = (psr_q[4:0] != SST_MODE_USER);
	assign cur_saved = cur_bank[3] ? bank_q[cur_bank[2:0]] : 32'h0000_0000;

	// ------------------------------------------------------------------
	// bus slave
	// ------------------------------------------------------------------
	// every access waits exactly one cycle so read data is always from a flop
	always_comb begin
		bus_d = bus_q;
		wait_d = 1'b1;
		rdata_d = rdata_q;
		op1_d = op1_q;
		opreg_d = opreg_q;
		shamt_d = shamt_q;
		instr_d = instr_q;
		iaddr_d = iaddr_q;
		if (bus_q == SST_BUS_IDLE) begin
			if (req) begin
				// capture read data now, release waitrequest next edge
				bus_d = SST_BUS_ANSWER;
				wait_d = 1'b0;
				// writes leave read data alone, so it stands until the next read
				if (avs_read) begin
					case (word_addr)
						SST_OFF_OPERAND1: rdata_d = op1_q;
						SST_OFF_OPERAND_REG: rdata_d = opreg_q;
						SST_OFF_SHIFT_AMOUNT: rdata_d = shamt_q;
						SST_OFF_INSTR: rdata_d = instr_q;
						SST_OFF_INSTR_ADDR: rdata_d = iaddr_q;
						SST_OFF_RESULT: rdata_d = result_q;
						SST_OFF_PC: rdata_d = pc_q;
						SST_OFF_STATUS_WORD: rdata_d = psr_q;
						SST_OFF_SAVED_WORD: rdata_d = cur_saved;
						SST_OFF_EXEC_INFO: rdata_d = {18'h0_0000, info_q};
						default: rdata_d = 32'h0000_0000; // unmapped and ctrl read zero
					endcase
				end
			end
		end else begin
			// answer edge; master drops or renews the request afterwards
			bus_d = SST_BUS_IDLE;
			if (wr_fire) begin
				case (word_addr)
					SST_OFF_OPERAND1: op1_d = sst_merge(op1_q, avs_writedata, avs_byteenable);
					SST_OFF_OPERAND_REG: opreg_d = sst_merge(opreg_q, avs_writedata, avs_byteenable);
					SST_OFF_SHIFT_AMOUNT: shamt_d = sst_merge(shamt_q, avs_writedata, avs_byteenable);
					SST_OFF_INSTR: instr_d = sst_merge(instr_q, avs_writedata, avs_byteenable);
					SST_OFF_INSTR_ADDR: iaddr_d = sst_merge(iaddr_q, avs_writedata, avs_byteenable);
					default: begin
						// status words and ctrl are handled by the execution group
					end
				endcase
			end
		end
	end

	// bus registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			bus_q <= SST_BUS_IDLE;
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			op1_q <= 32'h0000_0000;
			opreg_q <= 32'h0000_0000;
			shamt_q <= 32'h0000_0000;
			instr_q <= 32'h0000_0000;
			iaddr_q <= 32'h0000_0000;
		end else begin
			bus_q <= bus_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			op1_q <= op1_d;
			opreg_q <= opreg_d;
			shamt_q <= shamt_d;
			instr_q <= instr_d;
			iaddr_q <= iaddr_d;
		end
	end

	// ------------------------------------------------------------------
	// operand path
	// ------------------------------------------------------------------
	logic reg_shift; // register specified shift amount
	logic [31:0] pc_val; // program counter as operand
	logic [31:0] opa; // first operand after pc substitution
	logic [31:0] opm; // shifted operand before shifting
	logic [7:0] amt; // effective shift amount
	logic [32:0] sh; // shifter carry and result
	logic [31:0] imm_rot; // rotated immediate
	logic [32:0] op2; // second operand with shifter carry

	always_comb begin
		reg_shift = !instr_q[SST_IB_IMM] && instr_q[SST_IB_REG_SHIFT];
		pc_val = iaddr_q + (reg_shift ? SST_PC_AHEAD_REG : SST_PC_AHEAD_IMM); // see RULE12
		opa = (instr_q[19:16] == SST_REG_PC) ? pc_val : op1_q; // see RULE12
		opm = (instr_q[3:0] == SST_REG_PC) ? pc_val : opreg_q; // see RULE12
		if (reg_shift) begin
			amt = shamt_q[7:0]; // see RULE1
		end else if (instr_q[11:7] == 5'h00 && instr_q[6:5] != SST_SHIFT_LEFT_LOGICAL) begin
			amt = SST_SHIFT_32; // encoded zero means 32 for right shifts
		end else begin
			amt = {3'b000, instr_q[11:7]};
		end
		if (!reg_shift && instr_q[11:4] == 8'h06) begin
			sh = {opm[0], psr_q[SST_PSR_C], opm[31:1]}; // rotate right extended
		end else begin
			sh = sst_shift(opm, instr_q[6:5], amt, psr_q[SST_PSR_C]);
		end
		imm_rot = 32'({2{24'h00_0000, instr_q[7:0]}} >> {instr_q[11:8], 1'b0}); // see RULE9
		if (instr_q[SST_IB_IMM]) begin
			op2 = {(instr_q[11:8] == 4'h0) ? psr_q[SST_PSR_C] : imm_rot[31], imm_rot};
		end else begin
			op2 = sh;
		end
	end

	// ------------------------------------------------------------------
	// arithmetic and logic unit
	// ------------------------------------------------------------------
	logic [31:0] ax, ay; // adder inputs
	logic acin; // adder carry in
	logic [32:0] asum; // adder output
	logic [31:0] alu; // result
	logic alu_c, alu_v; // carry and overflow flags
	logic logical; // logical class opcode

	always_comb begin
		ax = opa;
		ay = op2[31:0];
		acin = 1'b0;
		logical = 1'b0;
		case (sst_opcode_t'(instr_q[24:21]))
			SST_OP_SUB, SST_COMPARE_OP: begin ay = ~op2[31:0]; acin = 1'b1; end
			SST_OP_RSB: begin ax = op2[31:0]; ay = ~opa; acin = 1'b1; end
			SST_OP_ADC: acin = psr_q[SST_PSR_C];
			SST_OP_SBC: begin ay = ~op2[31:0]; acin = psr_q[SST_PSR_C]; end
			SST_OP_RSC: begin ax = op2[31:0]; ay = ~opa; acin = psr_q[SST_PSR_C]; end
			SST_OP_ADD, SST_NEGATED_COMPARE_OP: acin = 1'b0;
			default: logical = 1'b1;
		endcase
		asum = {1'b0, ax} + {1'b0, ay} + {32'h0000_0000, acin};
		case (sst_opcode_t'(instr_q[24:21]))
			SST_OP_AND, SST_BIT_TEST_OP: alu = opa & op2[31:0];
			SST_OP_EOR, SST_EQUIVALENCE_TEST_OP: alu = opa ^ op2[31:0];
			SST_OP_ORR: alu = opa | op2[31:0];
			SST_OP_MOV: alu = op2[31:0];
			SST_OP_BIC: alu = opa & ~op2[31:0];
			SST_OP_MVN: alu = ~op2[31:0];
			default: alu = asum[31:0];
		endcase
		alu_c = logical ? op2[32] : asum[32]; // see RULE23
		alu_v = logical ? psr_q[SST_PSR_V] : ((ax[31] == ay[31]) && (asum[31] != ax[31]));
	end

	// ------------------------------------------------------------------
	// execution and status words
	// ------------------------------------------------------------------
	logic is_data; // data processing class
	logic is_test; // one of the four test opcodes
	logic is_psr; // status transfer encoding
	logic [31:0] psr_src; // status write source
	logic [31:0] psr_wmask; // bits a status write may change
	logic [31:0] flag_psr; // status word with fresh flags

	always_comb begin
		psr_d = psr_q;
		result_d = result_q;
		pc_d = pc_q;
		info_d = info_q;
		bank_wr = 1'b0;
		bank_wdata = 32'h0000_0000;
		is_data = (instr_q[27:26] == 2'b00);
		is_test = (instr_q[24:23] == 2'b10);
		is_psr = is_data && is_test && !instr_q[SST_IB_SET_FLAGS];
		psr_src = instr_q[SST_IB_IMM] ? imm_rot : opreg_q;
		psr_wmask = SST_PSR_FLAGS_MASK;
		if (instr_q[SST_IB_PSR_ALL] && (privileged || instr_q[SST_IB_PSR_SEL])) begin
			psr_wmask = SST_PSR_DEFINED_MASK; // see RULE17 see RULE18 see RULE20
		end
		flag_psr = psr_q;
		flag_psr[SST_PSR_N] = alu[31];
		flag_psr[SST_PSR_Z] = (alu == 32'h0000_0000);
		flag_psr[SST_PSR_C] = alu_c; // see RULE23
		flag_psr[SST_PSR_V] = alu_v;
		if (wr_fire && word_addr == SST_OFF_STATUS_WORD) begin
			// direct software access to the live status word
			psr_d = sst_merge(psr_q, avs_writedata, avs_byteenable) & SST_PSR_DEFINED_MASK;
		end else if (wr_fire && word_addr == SST_OFF_SAVED_WORD) begin
			bank_wr = cur_bank[3]; // see RULE19
			bank_wdata = sst_merge(cur_saved, avs_writedata, avs_byteenable)
				& SST_PSR_DEFINED_MASK;
		end else if (exec) begin
			info_d = '0;
			info_d.rd = instr_q[15:12];
			info_d.s_cycles = SST_S_CYCLES_NORMAL;
			if (!is_data) begin
				info_d.undef = 1'b1; // outside this operand path
			end else if (reg_shift && instr_q[SST_IB_MUL_GUARD]) begin
				info_d.undef = 1'b1; // see RULE8
			end else if (is_psr) begin
				if (!instr_q[SST_IB_PSR_DIR]) begin
					// status read into a general register, see RULE16
					result_d = instr_q[SST_IB_PSR_SEL] ? cur_saved : psr_q;
					info_d.rd_written = 1'b1;
					info_d.no_saved = instr_q[SST_IB_PSR_SEL] && !cur_bank[3];
				end else if (!instr_q[SST_IB_PSR_SEL]) begin
					psr_d = (psr_q & ~psr_wmask) | (psr_src & psr_wmask); // see RULE16 see RULE18
					info_d.flags_written = 1'b1;
				end else begin
					bank_wr = cur_bank[3]; // see RULE16 see RULE19
					bank_wdata = (cur_saved & ~psr_wmask) | (psr_src & psr_wmask);
					info_d.no_saved = !cur_bank[3];
				end
			end else begin
				info_d.i_cycles = reg_shift; // see RULE15
				if (instr_q[15:12] == SST_REG_PC) begin
					if (is_test) begin
						// legacy form: restore only where a saved word exists, see RULE14
						if (privileged && cur_bank[3]) begin
							psr_d = cur_saved;
							info_d.psr_restored = 1'b1;
						end
					end else begin
						pc_d = alu; // see RULE10 see RULE11
						info_d.pc_written = 1'b1;
						info_d.s_cycles = SST_S_CYCLES_PC; // see RULE15
						info_d.n_cycles = 1'b1;
						if (instr_q[SST_IB_SET_FLAGS]) begin
							info_d.no_saved = !cur_bank[3];
							if (cur_bank[3]) begin
								psr_d = cur_saved; // see RULE11
								info_d.psr_restored = 1'b1;
							end
						end
					end
				end else begin
					if (!is_test) begin
						result_d = alu;
						info_d.rd_written = 1'b1;
					end
					if (instr_q[SST_IB_SET_FLAGS]) begin
						psr_d = flag_psr; // see RULE13 see RULE23
						info_d.flags_written = 1'b1;
					end
				end
			end
		end
	end

	// execution registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			psr_q <= SST_PSR_RESET;
			result_q <= 32'h0000_0000;
			pc_q <= 32'h0000_0000;
			info_q <= '0;
			status_word_out <= SST_PSR_RESET;
		end else begin
			psr_q <= psr_d;
			result_q <= result_d;
			pc_q <= pc_d;
			info_q <= info_d;
			status_word_out <= psr_d;
		end
	end

	// ------------------------------------------------------------------
	// saved status banks
	// ------------------------------------------------------------------
	for (genvar g = 0; g < SST_NUM_BANKS; g++) begin : g_bank
		always_comb begin
			bank_d[g] = bank_q[g];
			if (bank_wr && (cur_bank[2:0] == 3'(g))) begin
				bank_d[g] = bank_wdata;
			end
		end
		always_ff @(posedge clk) begin
			if (sys_rst) begin
				bank_q[g] <= 32'h0000_0000;
			end else begin
				bank_q[g] <= bank_d[g];
			end
		end
	end

	assign avs_readdata = rdata_q;
	assign avs_waitrequest = wait_q;

endmodule // sst_core
`default_nettype wire

// ==== bench/sst_core_props.sv ====
// bus handshake and status word checks for sst_core
// assumes binding onto sst_core with one clock and a synchronous reset
`timescale 1ns/1ps
`default_nettype none
module sst_core_props (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// bus and status
	input wire logic [sst_pkg::SST_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [31:0] status_word_out
);
	import sst_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// a fresh request is answered after exactly one wait cycle
	a_ans_one_wait: assert property (avs_waitrequest && $past(avs_waitrequest)
		&& (avs_read || avs_write) |=> !avs_waitrequest) else $error("answer late");
	a_ans_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	a_ans_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
		else $error("answer without request");
	a_reset_vals: assert property ($fell(sys_rst) |-> avs_waitrequest
		&& avs_readdata == 32'h0 && status_word_out == SST_PSR_RESET) else $error("reset");
	a_rsvd_zero: assert property ((status_word_out & ~SST_PSR_DEFINED_MASK) == 32'h0)
		else $error("reserved status bit set");
	a_status_cause: assert property (!$stable(status_word_out)
		|-> $past(avs_write) || $past(avs_write, 2)) else $error("status moved alone");
	a_rdata_hold: assert property (!$stable(avs_readdata)
		|-> !avs_waitrequest && $past(avs_read)) else $error("read data moved");
	// user mode control bits only move through a direct bus write
	a_user_ctrl: assert property ($past(status_word_out[4:0]) == SST_MODE_USER
		&& status_word_out[27:0] != $past(status_word_out[27:0])
		|-> $past(avs_address[7:2]) == SST_OFF_STATUS_WORD[7:2]) else $error("control moved");
	c_exec: cover property (avs_write && !avs_waitrequest && avs_address == SST_OFF_CTRL);
	c_read: cover property (avs_read && !avs_waitrequest);
	c_user: cover property (status_word_out[4:0] == SST_MODE_USER);
endmodule // sst_core_props
bind sst_core sst_core_props chk_u (.clk, .sys_rst, .avs_address, .avs_read, .avs_write,
	.avs_readdata, .avs_waitrequest, .status_word_out);
`default_nettype wire

// ==== bench/sst_core_tb.sv ====
// self-checking bench for sst_core over its avalon slave
// assumes the one-wait-cycle answer and the register map of the package
`timescale 1ns/1ps
`default_nettype none
module sst_core_tb;
	import sst_pkg::*;
	logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
	logic [7:0] avs_address = 8'h00;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, status_word_out, p, v, r;
	logic [3:0] avs_byteenable = 4'hF;
	logic [7:0] am[8] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'h21, 8'h40, 8'h41, 8'hFF};
	logic [31:0] expq[$]; // expected read data, oldest first
	logic [31:0] xd; // expectation taken for the current answer
	logic [32:0] e; // carry and result expected
	int failures = 0, total_checks = 0, seed = 32'ha557_2853;
	always #4 clk = ~clk;
	sst_core dut_u (.clk, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_byteenable, .avs_readdata, .avs_waitrequest, .status_word_out);
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bad(string s);
		failures++;
		$display("[ERR] %0t %s", $time, s);
	endtask
	// one bus cycle, held until waitrequest is sampled low; bounded wait
	task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			bad("bus timeout");
			final_report();
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic ck(logic [7:0] a, logic [31:0] x);
		expq.push_back(x);
		acc(1'b0, a, 32'h0);
	endtask
	// every read answer takes the oldest expectation
	always @(posedge clk) begin
		if (avs_read && avs_waitrequest === 1'b0) begin
			xd = expq.pop_front();
			total_checks++;
			if (avs_readdata !== xd) bad("read data mismatch");
			// the status port is a registered copy of the word read here
			if (avs_address == SST_OFF_STATUS_WORD && status_word_out !== xd)
				bad("status port mismatch");
		end
	end
	task automatic ex(logic [31:0] i, logic [31:0] m);
		acc(1'b1, SST_OFF_OPERAND_REG, m);
		acc(1'b1, SST_OFF_INSTR, i);
		acc(1'b1, SST_OFF_CTRL, 32'h0000_0001);
	endtask
	// logical op with flag update: carry from the shifter, overflow kept
	task automatic fl();
		p = {e[31], e[31:0] == 32'h0, e[32], p[28:0]};
		ck(SST_OFF_RESULT, e[31:0]);
		ck(SST_OFF_STATUS_WORD, p);
	endtask
	// reference shifter: {carry, result}
	function automatic logic [32:0] shf(logic [1:0] t, logic [31:0] x, logic [7:0] a, logic c);
		logic [63:0] w;
		logic [5:0] k;
		logic [31:0] q;
		w = {x, 32'h0} >> a;
		k = (a[4:0] == 5'h0) ? 6'h20 : {1'b0, a[4:0]};
		q = (x >> k) | (x << (6'h20 - k));
		if (a == 8'h00) return {c, x};
		case (t)
			2'h0: return (a > 8'h20) ? 33'h0 : {x[32 - a], x << a};
			2'h1: return (a > 8'h20) ? 33'h0 : {w[31], w[63:32]};
			2'h2: return (a > 8'h1F) ? {33{x[31]}} :
				{w[31], w[63:32] | ~(32'hFFFF_FFFF >> a) & {32{x[31]}}};
			default: return {q[31], q};
		endcase
	endfunction
	initial begin
		p = SST_PSR_RESET;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		ck(SST_OFF_STATUS_WORD, p);
		ck(8'h3C, 32'h0);
		// four shift kinds over boundary amounts, junk above the low byte
		for (int i = 0; i < 32; i++) begin
			v = $random(seed);
			r = $random(seed);
			r[7:0] = am[i % 8];
			acc(1'b1, SST_OFF_SHIFT_AMOUNT, r);
			e = shf(2'(i / 8), v, r[7:0], p[SST_PSR_C]);
			ex(32'hE1B0_1010 | (i / 8) << 5, v);
			fl();
		end
		$display("shift tests done");
		for (int k = 0; k < 16; k++) begin
			v = $random(seed) & 32'h0000_00FF;
			e = shf(2'h3, v, 8'(2 * k), p[SST_PSR_C]);
			ex(32'hE3B0_1000 | k << 8 | v, 32'h0);
			fl();
		end
		$display("immediate tests done");
		acc(1'b1, SST_OFF_OPERAND1, v);
		ex(32'hE150_0000, v);
		p[31:28] = 4'h6;
		ck(SST_OFF_RESULT, e[31:0]);
		ck(SST_OFF_STATUS_WORD, p);
		acc(1'b1, SST_OFF_INSTR_ADDR, 32'h0000_1000);
		acc(1'b1, SST_OFF_SHIFT_AMOUNT, 32'h0);
		ex(32'hE1A0_100F, 32'h0);
		ck(SST_OFF_RESULT, 32'h0000_1008);
		ck(SST_OFF_EXEC_INFO, 32'h0000_0114);
		ex(32'hE1A0_101F, 32'h0);
		ck(SST_OFF_RESULT, 32'h0000_100C);
		ck(SST_OFF_EXEC_INFO, 32'h0000_0115);
		ex(32'hE1B0_1090, 32'h1234_5678);
		ck(SST_OFF_RESULT, 32'h0000_100C);
		ck(SST_OFF_STATUS_WORD, p);
		ex(32'hE1A0_F010, v);
		ck(SST_OFF_PC, v);
		ck(SST_OFF_EXEC_INFO, 32'h0000_02FB);
		ck(SST_OFF_STATUS_WORD, p);
		$display("operand tests done");
		acc(1'b1, SST_OFF_SAVED_WORD, 32'h2000_0010);
		ex(32'hE14F_1000, 32'h0);
		ck(SST_OFF_RESULT, 32'h2000_0010);
		ex(32'hE368_F20C, 32'h0);
		ck(SST_OFF_SAVED_WORD, 32'hC000_0010);
		ex(32'hE328_F20A, 32'h0);
		p[31:28] = 4'hA;
		ck(SST_OFF_STATUS_WORD, p);
		ex(32'hE1B0_F000, v);
		ck(SST_OFF_STATUS_WORD, 32'hC000_0010);
		ex(32'hE129_F000, 32'hF000_00D3);
		ck(SST_OFF_STATUS_WORD, 32'hF000_0010);
		ex(32'hE130_F000, 32'h0);
		ck(SST_OFF_STATUS_WORD, 32'hF000_0010);
		// mode change as read-modify-write of the word just read, state bit kept clear
		acc(1'b1, SST_OFF_STATUS_WORD, 32'hF000_0013);
		ex(32'hE129_F000, 32'h1000_00D3);
		ck(SST_OFF_STATUS_WORD, 32'h1000_00D3);
		ex(32'hE130_F000, 32'h0);
		ck(SST_OFF_STATUS_WORD, 32'hC000_0010);
		$display("status tests done");
		final_report();
	end
endmodule // sst_core_tb
`default_nettype wire
